// ==== design/cocc_map.vh ====
// Constant map for the code-option clock configuration block
`ifndef COCC_MAP_VH
`define COCC_MAP_VH

// Register byte offsets (APB, one word each)
`define COCC_ADDR_GENOPT    12'h000
`define COCC_ADDR_TRIM      12'h004
`define COCC_ADDR_MODE      12'h008
`define COCC_ADDR_CTRL      12'h00C
`define COCC_ADDR_STATUS    12'h010
`define COCC_ADDR_CUSTID    12'h014

// Option word layout
`define COCC_WORD_W         13
`define COCC_W0_NOISE_WIDTH_SELECT        11
`define COCC_W0_NRE         10
`define COCC_W0_SINGLE_CYCLE_SELECT        9
`define COCC_W0_CLKS_HI     8
`define COCC_W0_CLKS_LO     7
`define COCC_W0_WDT         6
`define COCC_W0_OSC_HI      5
`define COCC_W0_OSC_LO      3
`define COCC_W0_PR_HI       2
`define COCC_W0_PR_LO       0
`define COCC_W1_TRIM_HI     8
`define COCC_W1_TRIM_LO     4
`define COCC_W1_RCM_HI      3
`define COCC_W1_RCM_LO      2

// Values held until the option words are loaded
`define COCC_W0_RESET       13'h0200
`define COCC_W1_RESET       13'h0000
`define COCC_W2_RESET       13'h0000

// Oscillator mode codes
`define COCC_OSC_XT         3'h0
`define COCC_OSC_HXT        3'h1
`define COCC_OSC_LXT1       3'h2
`define COCC_OSC_LOW_CRYSTAL_32K_MODE       3'h3
`define COCC_OSC_IRC_IO     3'h4
`define COCC_OSC_IRC_OUT    3'h5
`define COCC_OSC_ERC_IO     3'h6
`define COCC_OSC_ERC_OUT    3'h7

// RC frequency select codes and their frequencies in kHz
`define COCC_RCM_4M         2'h0
`define COCC_RCM_16M        2'h1
`define COCC_RCM_3M58       2'h2
`define COCC_RCM_455K       2'h3
`define COCC_KHZ_4M         16'h0FA0
`define COCC_KHZ_16M        16'h3E80
`define COCC_KHZ_3M58       16'h0DFC
`define COCC_KHZ_455K       16'h01C7

// Clocks per instruction period
`define COCC_CLKS_4         2'h0
`define COCC_CLKS_2         2'h1
`define COCC_CLKS_8         2'h2
`define COCC_CLKS_16        2'h3
`define COCC_CPI_4          5'h04
`define COCC_CPI_2          5'h02
`define COCC_CPI_8          5'h08
`define COCC_CPI_16         5'h10

// Trim groups by the two upper code bits, with their rank bases
`define COCC_TRIM_GRP_SLOW  2'h3
`define COCC_TRIM_GRP_LOW   2'h1
`define COCC_TRIM_GRP_NOM   2'h0
`define COCC_TRIM_BASE_SLOW 5'h00
`define COCC_TRIM_BASE_LOW  5'h08
`define COCC_TRIM_BASE_NOM  5'h10
`define COCC_TRIM_BASE_FAST 5'h18
`define COCC_TRIM_TOP       3'h7

// Noise rejection widths in oscillator periods
`define COCC_NOISE_SHORT    6'h08
`define COCC_NOISE_LONG     6'h20

// Control and status bits
`define COCC_CTRL_EVT_EN    0
`define COCC_STAT_EVT       0
`define COCC_STAT_LOADED    1

`endif

// ==== design/cocc_int_filter.v ====
// External interrupt falling-edge detector with noise rejection
`timescale 1ns/1ps
`default_nettype none
`include "cocc_map.vh"

module cocc_int_filter (
    input  wire       clk,
    input  wire       rst,
    input  wire       extIntPin,
    input  wire       filterOn,
    input  wire       shortWidth,
    output reg        intFall
);
    localparam IDLE = 1'b0;
    localparam WAIT = 1'b1;

    reg       sync1;
    reg       sync2;
    reg       sync3;
    reg       stableLvl;
    reg       prevLvl;
    reg       state;
    reg [5:0] cnt;
    wire      fall;
    wire [5:0] need;

    assign fall = prevLvl & ~stableLvl;
    assign need = shortWidth ? `COCC_NOISE_SHORT : `COCC_NOISE_LONG;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1     <= 1'b1;
            sync2     <= 1'b1;
            sync3     <= 1'b1;
            stableLvl <= 1'b1;
            prevLvl   <= 1'b1;
        end else begin
            sync1   <= extIntPin;
            sync2   <= sync1;
            sync3   <= sync2;
            prevLvl <= stableLvl;
            if (sync2 == sync3) begin
                stableLvl <= sync3;
            end
        end
    end

    // A low pulse counts only after it has held the whole width
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= IDLE;
            cnt     <= 6'h00;
            intFall <= 1'b0;
        end else begin
            intFall <= 1'b0;
            case (state)
                IDLE: begin
                    if (fall && !filterOn) begin
                        intFall <= 1'b1;
                    end else if (fall) begin
                        cnt   <= 6'h01;
                        state <= WAIT;
                    end
                end
                WAIT: begin
                    if (stableLvl || !filterOn) begin
                        state <= IDLE;
                    end else if (cnt == need - 6'h01) begin
                        intFall <= 1'b1;
                        state   <= IDLE;
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule // cocc_int_filter
`default_nettype wire

// ==== design/cocc_top.v ====
// Code-option decoder: clock, watchdog, protection and interrupt filter setup
//
// Operation
// - Internal RC runs at 4 MHz by default; other frequencies via select field.
// - RC select 00=4 MHz, 01=16 MHz, 10=3.58 MHz, 11=455 kHz.
// - Five-bit trim field in word 1 calibrates each RC frequency.
// - Trim codes map to a monotonic speed rank, slowest 11111, fastest 10111.
// - Program cannot write option words; they are read-only here.
// - Three 13-bit option words are held: general, trim, customer id.
// - Width bit 1 accepts 8-period pulses, 0 needs 32 periods.
// - Interrupt input triggers on falling edge, filtered when rejection on.
// - Rejection enable bit: 0 turns filter on, 1 turns it off.
// - Rejection forced off in low crystal modes and in sleep.
// - Cycle bit 1 selects one instruction cycle, 0 selects two.
// - Period field 00=4, 01=2, 10=8, 11=16 clocks.
// - Watchdog bit 1 enables the watchdog, 0 disables it.
// - Bits 5-3 select oscillator mode, bits 2-0 code protection.
// - Modes 000 XT, 001 HIGH_CRYSTAL_MODE, 010 LXT1, 011 LOW_CRYSTAL_32K_MODE, 100/101 internal RC.
// - Modes 110 external RC with I/O pin, 111 with RC clock out.
// - Code protection on for any nonzero field, off only for 000.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cocc_map.vh"

module cocc_top (
    input  wire        clk,
    input  wire        rst,
    input  wire [12:0] optWord0,
    input  wire [12:0] optWord1,
    input  wire [12:0] optWord2,
    input  wire        sleepMode,
    input  wire        extIntPin,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         optLoaded,
    output reg  [15:0] rcFreqKhz,
    output reg  [4:0]  trimRank,
    output reg  [2:0]  oscMode,
    output reg         crystalMode,
    output reg         highCrystalMode,
    output reg         lowCrystalMode,
    output reg         lowCrystal32kMode,
    output reg         internalRcMode,
    output reg         externalRcMode,
    output reg         rcClockOut,
    output reg         singleCycleSelect,
    output reg  [4:0]  clksPerInstr,
    output reg         watchdogOn,
    output reg         codeProtect,
    output reg         noiseFilterOn,
    output reg         noiseWidthSelect,
    output reg         extIntEvent
);
    reg  [12:0] word0;
    reg  [12:0] word1;
    reg  [12:0] word2;
    reg         ctrlEvtEn;
    reg         evtSticky;
    wire        intFall;
    wire        apbAccess;
    wire        apbWrite;
    wire        setupPhase;

    // Option word fields
    wire        noise_width_select   = word0[`COCC_W0_NOISE_WIDTH_SELECT];
    wire        noise_filter_disable = word0[`COCC_W0_NRE];
    wire        single_cycle_select  = word0[`COCC_W0_SINGLE_CYCLE_SELECT];
    wire [1:0]  instr_period_sel     = word0[`COCC_W0_CLKS_HI:`COCC_W0_CLKS_LO];
    wire        watchdog_on          = word0[`COCC_W0_WDT];
    wire [2:0]  osc_mode             = word0[`COCC_W0_OSC_HI:`COCC_W0_OSC_LO];
    wire [2:0]  protect              = word0[`COCC_W0_PR_HI:`COCC_W0_PR_LO];
    wire [4:0]  trim                 = word1[`COCC_W1_TRIM_HI:`COCC_W1_TRIM_LO];
    wire [1:0]  rc_freq_sel          = word1[`COCC_W1_RCM_HI:`COCC_W1_RCM_LO];

    reg  [15:0] next_rcFreqKhz;
    reg  [4:0]  next_clksPerInstr;
    reg         next_lowXtal;
    reg         next_filterOn;
    reg  [31:0] next_prdata;
    reg         next_pslverr;

    // Rank 0 is the slowest trim code, rank 31 the fastest
    function [4:0] trim_rank;
        input [4:0] code;
        begin
            case (code[4:3])
                `COCC_TRIM_GRP_SLOW:
                    trim_rank = `COCC_TRIM_BASE_SLOW + {2'h0, `COCC_TRIM_TOP - code[2:0]};
                `COCC_TRIM_GRP_LOW:
                    trim_rank = `COCC_TRIM_BASE_LOW + {2'h0, `COCC_TRIM_TOP - code[2:0]};
                `COCC_TRIM_GRP_NOM:
                    trim_rank = `COCC_TRIM_BASE_NOM + {2'h0, code[2:0]};
                default:
                    trim_rank = `COCC_TRIM_BASE_FAST + {2'h0, code[2:0]};
            endcase
        end
    endfunction

    // Either low crystal code counts as a low crystal mode
    function is_low_xtal;
        input [2:0] mode;
        begin
            is_low_xtal = (mode == `COCC_OSC_LXT1) || (mode == `COCC_OSC_LOW_CRYSTAL_32K_MODE);
        end
    endfunction

    // Option words: pins are treated as static straps, caught once after release
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            word0     <= `COCC_W0_RESET;
            word1     <= `COCC_W1_RESET;
            word2     <= `COCC_W2_RESET;
            optLoaded <= 1'b0;
        end else if (!optLoaded) begin
            word0     <= {1'b0, optWord0[11:0]};
            word1     <= optWord1;
            word2     <= optWord2;
            optLoaded <= 1'b1;
        end
    end

    always @* begin
        case (rc_freq_sel)
            `COCC_RCM_4M:   next_rcFreqKhz = `COCC_KHZ_4M;
            `COCC_RCM_16M:  next_rcFreqKhz = `COCC_KHZ_16M;
            `COCC_RCM_3M58: next_rcFreqKhz = `COCC_KHZ_3M58;
            default:        next_rcFreqKhz = `COCC_KHZ_455K;
        endcase
        case (instr_period_sel)
            `COCC_CLKS_4:  next_clksPerInstr = `COCC_CPI_4;
            `COCC_CLKS_2:  next_clksPerInstr = `COCC_CPI_2;
            `COCC_CLKS_8:  next_clksPerInstr = `COCC_CPI_8;
            default:       next_clksPerInstr = `COCC_CPI_16;
        endcase
        next_lowXtal  = is_low_xtal(osc_mode);
        // Low crystal and sleep override the enable bit
        next_filterOn = ~noise_filter_disable & ~next_lowXtal & ~sleepMode;
    end

    // Decoded configuration, registered so every output leaves a flip-flop
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rcFreqKhz         <= `COCC_KHZ_4M;
            trimRank          <= `COCC_TRIM_BASE_NOM;
            oscMode           <= `COCC_OSC_XT;
            crystalMode       <= 1'b0;
            highCrystalMode   <= 1'b0;
            lowCrystalMode    <= 1'b0;
            lowCrystal32kMode <= 1'b0;
            internalRcMode    <= 1'b0;
            externalRcMode    <= 1'b0;
            rcClockOut        <= 1'b0;
            singleCycleSelect <= 1'b1;
            clksPerInstr      <= `COCC_CPI_4;
            watchdogOn        <= 1'b0;
            codeProtect       <= 1'b0;
            noiseFilterOn     <= 1'b0;
            noiseWidthSelect  <= 1'b0;
        end else begin
            rcFreqKhz         <= next_rcFreqKhz;
            trimRank          <= trim_rank(trim);
            oscMode           <= osc_mode;
            crystalMode       <= (osc_mode == `COCC_OSC_XT);
            highCrystalMode   <= (osc_mode == `COCC_OSC_HXT);
            lowCrystalMode    <= next_lowXtal;
            lowCrystal32kMode <= (osc_mode == `COCC_OSC_LOW_CRYSTAL_32K_MODE);
            internalRcMode    <= (osc_mode == `COCC_OSC_IRC_IO) ||
                                 (osc_mode == `COCC_OSC_IRC_OUT);
            externalRcMode    <= (osc_mode == `COCC_OSC_ERC_IO) ||
                                 (osc_mode == `COCC_OSC_ERC_OUT);
            rcClockOut        <= (osc_mode == `COCC_OSC_IRC_OUT) ||
                                 (osc_mode == `COCC_OSC_ERC_OUT);
            singleCycleSelect <= single_cycle_select;
            clksPerInstr      <= next_clksPerInstr;
            watchdogOn        <= watchdog_on;
            codeProtect       <= |protect;
            noiseFilterOn     <= next_filterOn;
            noiseWidthSelect  <= noise_width_select;
        end
    end

    // Filter sees the combined enable, so sleep takes effect without delay
    cocc_int_filter u_filter (
        .clk        (clk),
        .rst        (rst),
        .extIntPin  (extIntPin),
        .filterOn   (next_filterOn),
        .shortWidth (noise_width_select),
        .intFall    (intFall)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            extIntEvent <= 1'b0;
        end else begin
            extIntEvent <= intFall;
        end
    end

    // APB slave: pready is registered from the setup cycle, so it is high in the first access cycle and no wait states are added
    assign setupPhase = psel & ~penable;
    assign apbAccess  = psel & penable & pready;
    assign apbWrite   = apbAccess & pwrite;

    always @* begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `COCC_ADDR_GENOPT: begin
                next_prdata[12:0] = word0;
                next_pslverr      = pwrite;
            end
            `COCC_ADDR_TRIM: begin
                next_prdata[4:0]  = trimRank;
                next_prdata[12:8] = trim;
                next_prdata[31:16] = rcFreqKhz;
                next_pslverr      = pwrite;
            end
            `COCC_ADDR_MODE: begin
                next_prdata[2:0]  = oscMode;
                next_prdata[3]    = codeProtect;
                next_prdata[4]    = watchdogOn;
                next_prdata[5]    = singleCycleSelect;
                next_prdata[12:8] = clksPerInstr;
                next_prdata[16]   = noiseFilterOn;
                next_prdata[17]   = noiseWidthSelect;
                next_pslverr      = pwrite;
            end
            `COCC_ADDR_CTRL: begin
                next_prdata[`COCC_CTRL_EVT_EN] = ctrlEvtEn;
            end
            `COCC_ADDR_STATUS: begin
                next_prdata[`COCC_STAT_EVT]    = evtSticky;
                next_prdata[`COCC_STAT_LOADED] = optLoaded;
            end
            `COCC_ADDR_CUSTID: begin
                next_prdata[12:0] = word2;
                next_pslverr      = pwrite;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            if (setupPhase) begin
                prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_pslverr;
            end else begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Control and sticky event; a new event beats a same-cycle clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlEvtEn <= 1'b0;
            evtSticky <= 1'b0;
        end else begin
            if (apbWrite && paddr == `COCC_ADDR_CTRL) begin
                ctrlEvtEn <= pwdata[`COCC_CTRL_EVT_EN];
            end
            if (intFall && ctrlEvtEn) begin
                evtSticky <= 1'b1;
            end else if (apbWrite && paddr == `COCC_ADDR_STATUS &&
                         pwdata[`COCC_STAT_EVT]) begin
                evtSticky <= 1'b0;
            end
        end
    end
endmodule // cocc_top
`default_nettype wire

// ==== test/cocc_checker.sv ====
// Assertion checker for the code-option clock configuration block
`timescale 1ns/1ps
`default_nettype none
module cocc_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [12:0] optWord0,
    input wire logic [12:0] optWord1,
    input wire logic        sleepMode,
    input wire logic        extIntPin,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        optLoaded,
    input wire logic [15:0] rcFreqKhz,
    input wire logic [4:0]  trimRank,
    input wire logic [2:0]  oscMode,
    input wire logic        externalRcMode,
    input wire logic        rcClockOut,
    input wire logic        singleCycleSelect,
    input wire logic [4:0]  clksPerInstr,
    input wire logic        watchdogOn,
    input wire logic        codeProtect,
    input wire logic        noiseFilterOn,
    input wire logic        noiseWidthSelect,
    input wire logic        extIntEvent
);
    // Own copy of the captured words, so pin changes after capture are not followed
    logic [12:0] cw0;
    logic [12:0] cw1;
    logic        settled;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cw0 <= 13'h0000;
            cw1 <= 13'h0000;
            settled <= 1'b0;
        end else begin
            if (!optLoaded) begin
                cw0 <= optWord0;
                cw1 <= optWord1;
            end
            settled <= optLoaded;
        end
    end
    function automatic logic [4:0] rankOf(input logic [4:0] c);
        case (c[4:3])
            2'b11:   rankOf = 5'h07 - {2'b00, c[2:0]};
            2'b01:   rankOf = 5'h0F - {2'b00, c[2:0]};
            2'b00:   rankOf = 5'h10 + {2'b00, c[2:0]};
            default: rankOf = 5'h18 + {2'b00, c[2:0]};
        endcase
    endfunction
    function automatic logic [15:0] khzOf(input logic [1:0] s);
        case (s)
            2'b00:   khzOf = 16'h0FA0;
            2'b01:   khzOf = 16'h3E80;
            2'b10:   khzOf = 16'h0DFC;
            default: khzOf = 16'h01C7;
        endcase
    endfunction
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_rc_freq: assert property (settled |-> rcFreqKhz == khzOf(cw1[3:2]))
        else $error("rc frequency wrong");
    a_trim_rank: assert property (settled |-> trimRank == rankOf(cw1[8:4]))
        else $error("trim rank wrong");
    a_osc_mode: assert property (settled |-> oscMode == cw0[5:3])
        else $error("oscillator mode wrong");
    a_ext_rc: assert property (settled |-> externalRcMode == (cw0[5:4] == 2'b11)
        && rcClockOut == (cw0[5] && cw0[3])) else $error("rc mode flags wrong");
    a_protect_on: assert property (settled |-> codeProtect == (cw0[2:0] != 3'h0))
        else $error("protection wrong");
    a_cycle_sel: assert property (settled |-> singleCycleSelect == cw0[9]
        && watchdogOn == cw0[6] && clksPerInstr == (5'h02 << {cw0[8], !cw0[7] ^ cw0[8]}))
        else $error("cycle options wrong");
    a_filter_on: assert property (settled |-> noiseFilterOn == (!cw0[10]
        && cw0[5:4] != 2'b01 && !$past(sleepMode))) else $error("filter enable wrong");
    a_width_sel: assert property (settled |-> noiseWidthSelect == cw0[11])
        else $error("width select wrong");
    a_short_drop: assert property (extIntEvent && noiseFilterOn && noiseWidthSelect
        |-> !$past(extIntPin, 8)) else $error("short pulse accepted");
    a_event_once: assert property (extIntEvent |=> !extIntEvent)
        else $error("event longer than one cycle");
    a_opt_hold: assert property (settled |=> $stable(oscMode) && $stable(rcFreqKhz))
        else $error("option outputs moved");
    a_gen_refuse: assert property (psel && penable && pwrite && pready
        && paddr == 12'h000 |-> pslverr) else $error("option write accepted");
endmodule // cocc_checker
`default_nettype wire

// ==== test/cocc_top_tb.sv ====
// Self-checking testbench for the code-option clock configuration block
`timescale 1ns/1ps
`default_nettype none
`include "cocc_map.vh"
module cocc_top_tb;
    logic        clk;
    logic        rst;
    logic [12:0] optWord0;
    logic [12:0] optWord1;
    logic [12:0] optWord2;
    logic        sleepMode;
    logic        extIntPin;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        optLoaded;
    logic [15:0] rcFreqKhz;
    logic [4:0]  trimRank;
    logic [2:0]  oscMode;
    logic        xtM;
    logic        hxtM;
    logic        lxtM;
    logic        lxt32M;
    logic        ircM;
    logic        ercM;
    logic        rcOut;
    logic        single;
    logic [4:0]  cpiOut;
    logic        wdtOn;
    logic        codeProtect;
    logic        filterOn;
    logic        widthSel;
    logic        extIntEvent;
    int          fails;
    int          numChecks;
    int          evtCount = 0;
    logic [31:0] rd;
    logic        err;
    cocc_top cocc_top_inst (.clk(clk), .rst(rst), .optWord0(optWord0), .optWord1(optWord1),
        .optWord2(optWord2), .sleepMode(sleepMode), .extIntPin(extIntPin), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .optLoaded(optLoaded), .rcFreqKhz(rcFreqKhz),
        .trimRank(trimRank), .oscMode(oscMode), .crystalMode(xtM), .highCrystalMode(hxtM),
        .lowCrystalMode(lxtM), .lowCrystal32kMode(lxt32M), .internalRcMode(ircM),
        .externalRcMode(ercM), .rcClockOut(rcOut), .singleCycleSelect(single),
        .clksPerInstr(cpiOut), .watchdogOn(wdtOn), .codeProtect(codeProtect),
        .noiseFilterOn(filterOn), .noiseWidthSelect(widthSel), .extIntEvent(extIntEvent));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (extIntEvent === 1'b1)
            evtCount <= evtCount + 1;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks=%0d fails=%0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Holds the request until pready; a hung slave is cut off after 20 cycles
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Option words only load at reset, so each setting needs a fresh reset
    task automatic do_reset(input logic [12:0] w0, input logic [12:0] w1, input logic [12:0] w2);
        rst <= 1'b1;
        optWord0 <= w0;
        optWord1 <= w1;
        optWord2 <= w2;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse(input int low, input int exp);
        int c0;
        c0 = evtCount;
        extIntPin <= 1'b0;
        repeat (low) @(posedge clk);
        extIntPin <= 1'b1;
        repeat (60) @(posedge clk);
        chk(evtCount - c0, exp);
    endtask
    task automatic t_decode;
        logic [12:0] w;
        logic [4:0]  cpi [4];
        cpi = '{5'h04, 5'h02, 5'h08, 5'h10};
        for (int i = 0; i < 8; i++) begin
            w = {1'b1, i[2], i == 5, i[0], i[1:0], i[1], i[2:0], i[2:0]};
            do_reset(w, 13'h0000, 13'h0000);
            chk(oscMode, i[2:0]);
            chk({xtM, hxtM, lxtM, lxt32M}, {i == 0, i == 1, i[2:1] == 2'b01, i == 3});
            chk({ircM, ercM, rcOut}, {i[2:1] == 2'b10, i[2:1] == 2'b11, i == 5 || i == 7});
            chk(codeProtect, i != 0);
            chk({single, wdtOn, cpiOut}, {i[0], i[1], cpi[i[1:0]]});
            chk({widthSel, filterOn}, {i[2], i != 5 && i[2:1] != 2'b01});
            apb(1'b0, `COCC_ADDR_GENOPT, 32'h0000_0000);
            chk(rd, {20'h0_0000, w[11:0]});
        end
    endtask
    task automatic t_rc;
        logic [4:0]  c;
        logic [15:0] khz [4];
        khz = '{16'h0FA0, 16'h3E80, 16'h0DFC, 16'h01C7};
        for (int r = 0; r < 32; r++) begin
            c = r < 8 ? 5'(31 - r) : r < 16 ? 5'(23 - r) : r < 24 ? 5'(r - 16) : 5'(r - 8);
            do_reset(13'h0200, {4'h0, c, r[1:0], 2'b00}, 13'h0000);
            chk(trimRank, r[4:0]);
            chk(rcFreqKhz, khz[r[1:0]]);
            apb(1'b0, `COCC_ADDR_TRIM, 32'h0000_0000);
            chk(rd, {khz[r[1:0]], 3'h0, c, 3'h0, r[4:0]});
        end
    endtask
    task automatic t_apb;
        do_reset(13'h0A5B, 13'h0000, 13'h1C3D);
        apb(1'b1, `COCC_ADDR_GENOPT, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b1, `COCC_ADDR_MODE, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, `COCC_ADDR_GENOPT, 32'h0000_0000);
        chk({err, rd, oscMode}, {1'b0, 32'h0000_0A5B, 3'h3});
        apb(1'b0, `COCC_ADDR_MODE, 32'h0000_0000);
        chk({err, rd}, {1'b0, 32'h0002_043B});
        apb(1'b0, `COCC_ADDR_CUSTID, 32'h0000_0000);
        chk({err, rd}, {1'b0, 32'h0000_1C3D});
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        // Pins change after capture and must be ignored until the next reset
        do_reset(13'h0208, 13'h0004, 13'h0000);
        optWord0 <= 13'h0038;
        optWord1 <= 13'h000C;
        repeat (4) @(posedge clk);
        chk({optLoaded, oscMode, rcFreqKhz}, {1'b1, 3'h1, 16'h3E80});
    endtask
    task automatic t_int;
        do_reset(13'h0400, 13'h0000, 13'h0000);
        apb(1'b1, `COCC_ADDR_CTRL, 32'h0000_0001);
        pulse(4, 1);
        apb(1'b0, `COCC_ADDR_STATUS, 32'h0000_0000);
        chk(rd[0], 1'b1);
        // Sticky event clears on a one written back; loaded flag stays
        apb(1'b1, `COCC_ADDR_STATUS, 32'h0000_0001);
        apb(1'b0, `COCC_ADDR_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'b10);
        do_reset(13'h0800, 13'h0000, 13'h0000);
        pulse(5, 0);
        pulse(14, 1);
        do_reset(13'h0000, 13'h0000, 13'h0000);
        pulse(20, 0);
        pulse(40, 1);
        sleepMode <= 1'b1;
        repeat (2) @(posedge clk);
        chk(filterOn, 1'b0);
        pulse(5, 1);
        sleepMode <= 1'b0;
        do_reset(13'h0018, 13'h0000, 13'h0000);
        pulse(5, 1);
    endtask
    initial begin
        fails = 0;
        numChecks = 0;
        rst = 1'b1;
        optWord0 = 13'h0200;
        optWord1 = 13'h0000;
        optWord2 = 13'h0000;
        sleepMode = 1'b0;
        extIntPin = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        t_decode;
        t_rc;
        t_apb;
        t_int;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report;
    end
endmodule // cocc_top_tb
bind cocc_top cocc_checker cocc_checker_inst (.clk(clk), .rst(rst), .optWord0(optWord0),
    .optWord1(optWord1), .sleepMode(sleepMode), .extIntPin(extIntPin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .optLoaded(optLoaded), .rcFreqKhz(rcFreqKhz), .trimRank(trimRank), .oscMode(oscMode),
    .externalRcMode(externalRcMode), .rcClockOut(rcClockOut),
    .singleCycleSelect(singleCycleSelect), .clksPerInstr(clksPerInstr),
    .watchdogOn(watchdogOn), .codeProtect(codeProtect), .noiseFilterOn(noiseFilterOn),
    .noiseWidthSelect(noiseWidthSelect), .extIntEvent(extIntEvent));
`default_nettype wire
